/* design/aesbe_params.svh */
// constants of the block cipher engine: addresses, fields, codes and timing
`ifndef AESBE_PARAMS_SVH
`define AESBE_PARAMS_SVH

// -----------------------------------------------------------------------
// register addresses on the serial link
// -----------------------------------------------------------------------
`define AESBE_ADDR_STATUS 8'h82
`define AESBE_ADDR_CTRL 8'h83
`define AESBE_ADDR_DATA_FIRST 8'h84
`define AESBE_ADDR_DATA_LAST 8'h93
`define AESBE_ADDR_CTRL_ALIAS 8'h94
`define AESBE_DATA_BYTES 5'h10

// -----------------------------------------------------------------------
// field positions, codes and reset values
// -----------------------------------------------------------------------
`define AESBE_STAT_ERR_BIT 7
`define AESBE_STAT_DONE_BIT 0
`define AESBE_CTRL_START_BIT 7
`define AESBE_CTRL_MODE_HI 6
`define AESBE_CTRL_MODE_LO 4
`define AESBE_CTRL_DIR_BIT 3
`define AESBE_MODE_ECB 3'h0
`define AESBE_MODE_KEY 3'h1
`define AESBE_MODE_CBC 3'h2
`define AESBE_STATUS_RESET 8'h00
`define AESBE_CTRL_RESET 8'h00
`define AESBE_CMD_READ 2'h0
`define AESBE_CMD_WRITE 2'h1

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define AESBE_CLK_PERIOD_NS 10
`define AESBE_T_AES_NS 23400
`define AESBE_T_DONE_MAX_NS 24000
`define AESBE_OP_CYCLES ((`AESBE_T_AES_NS + `AESBE_CLK_PERIOD_NS - 1) / `AESBE_CLK_PERIOD_NS)
`define AESBE_DONE_MAX_CYCLES (`AESBE_T_DONE_MAX_NS / `AESBE_CLK_PERIOD_NS)
`define AESBE_CORE_LATENCY 16

`endif

/* design/aesbe_pkg.sv */
// types shared by the block cipher engine files
package aesbe_pkg;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_IGNORE} aesbe_phase_t;
  typedef enum logic {ENG_IDLE, ENG_RUN} aesbe_eng_t;
  typedef logic [7:0] aesbe_byte_t;
endpackage

/* design/aesbe_core.sv */
// iterative 128-bit block cipher core, one round per clock
`timescale 1ns/1ns
module aesbe_core
  import aesbe_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command
  input wire logic start,
  input wire logic decrypt,
  input wire logic [127:0] key_in,
  input wire logic [127:0] data_in,
  // result, held until the next start
  output logic [127:0] data_out,
  output logic [127:0] key_out
);
  localparam logic [3:0] ROUNDS = 4'hA;

  logic [127:0] st, next_st, rk, next_rk;
  logic [3:0] rnd, next_rnd;
  logic run, next_run, dec, next_dec;

  function automatic aesbe_byte_t gmul(input aesbe_byte_t a, input aesbe_byte_t b);
    aesbe_byte_t p, x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
    end
    return p;
  endfunction

  // field inverse as x^254
  function automatic aesbe_byte_t ginv(input aesbe_byte_t x);
    aesbe_byte_t r, s;
    r = 8'h01;
    s = x;
    for (int i = 0; i < 7; i++) begin
      s = gmul(s, s);
      r = gmul(r, s);
    end
    return r;
  endfunction

  function automatic aesbe_byte_t rotl(input aesbe_byte_t b, input int n);
    logic [15:0] d;
    d = {b, b} << n;
    return d[15:8];
  endfunction

  function automatic aesbe_byte_t sb(input aesbe_byte_t x);
    aesbe_byte_t i;
    i = ginv(x);
    return i ^ rotl(i, 1) ^ rotl(i, 2) ^ rotl(i, 3) ^ rotl(i, 4) ^ 8'h63;
  endfunction

  function automatic aesbe_byte_t isb(input aesbe_byte_t x);
    return ginv(rotl(x, 1) ^ rotl(x, 3) ^ rotl(x, 6) ^ 8'h05);
  endfunction

  function automatic aesbe_byte_t bget(input logic [127:0] v, input int i);
    return v[127-8*i -: 8];
  endfunction

  function automatic logic [127:0] sub_shift(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? ((c + 4 - r) % 4) * 4 + r : ((c + r) % 4) * 4 + r;
        o[127-8*(c*4+r) -: 8] = inv ? isb(bget(s, src)) : sb(bget(s, src));
      end
    end
    return o;
  endfunction

  function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [31:0] m;
    aesbe_byte_t acc;
    o = '0;
    m = inv ? 32'h0E0B0D09 : 32'h02030101;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++) acc = acc ^ gmul(bget(s, c*4 + (r+j)%4), m[31-8*j -: 8]);
        o[127-8*(c*4+r) -: 8] = acc;
      end
    end
    return o;
  endfunction

  function automatic aesbe_byte_t rcon(input logic [3:0] i);
    aesbe_byte_t r;
    r = 8'h01;
    for (int j = 1; j < 10; j++) begin
      if (j < int'(i)) r = gmul(r, 8'h02);
    end
    return r;
  endfunction

  function automatic logic [31:0] kcore(input logic [31:0] w, input aesbe_byte_t rc);
    logic [31:0] r;
    r = {w[23:0], w[31:24]};
    return {sb(r[31:24]) ^ rc, sb(r[23:16]), sb(r[15:8]), sb(r[7:0])};
  endfunction

  function automatic logic [127:0] key_fwd(input logic [127:0] k, input aesbe_byte_t rc);
    logic [31:0] n0, n1, n2, n3;
    n0 = k[127:96] ^ kcore(k[31:0], rc);
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    n3 = k[31:0] ^ n2;
    return {n0, n1, n2, n3};
  endfunction

  function automatic logic [127:0] key_back(input logic [127:0] k, input aesbe_byte_t rc);
    logic [31:0] p1, p2, p3;
    p3 = k[31:0] ^ k[63:32];
    p2 = k[63:32] ^ k[95:64];
    p1 = k[95:64] ^ k[127:96];
    return {k[127:96] ^ kcore(p3, rc), p1, p2, p3};
  endfunction

  always_comb begin
    logic [127:0] s, nk;
    s = '0;
    nk = '0;
    next_st = st;
    next_rk = rk;
    next_rnd = rnd;
    next_run = run;
    next_dec = dec;
    if (start) begin
      next_st = data_in ^ key_in;
      next_rk = key_in;
      next_rnd = 4'h1;
      next_run = 1'b1;
      next_dec = decrypt;
    end else if (run) begin
      if (!dec) begin
        nk = key_fwd(rk, rcon(rnd));
        s = sub_shift(st, 1'b0);
        next_st = ((rnd == ROUNDS) ? s : mix(s, 1'b0)) ^ nk;
      end else begin
        // walk the schedule backwards from the last round key
        nk = key_back(rk, rcon(ROUNDS + 4'h1 - rnd));
        s = sub_shift(st, 1'b1) ^ nk;
        next_st = (rnd == ROUNDS) ? s : mix(s, 1'b1);
      end
      next_rk = nk;
      next_rnd = rnd + 4'h1;
      next_run = (rnd != ROUNDS);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      rk <= '0;
      rnd <= 4'h0;
      run <= 1'b0;
      dec <= 1'b0;
    end else begin
      st <= next_st;
      rk <= next_rk;
      rnd <= next_rnd;
      run <= next_run;
      dec <= next_dec;
    end
  end

  assign data_out = st;
  assign key_out = rk;
endmodule

/* design/aesbe_engine.sv */
// block cipher engine reached by memory-style accesses over the serial link
// Contract
// - core runs at core rate, fixed run time
// - fast access over control through alias address
// - old byte shifted out one byte later
// - fast access applies to every write automatically
// - data write replaces previous result
// - start bit at control or alias launches
// - alias address mirrors the control register
// - done flag set within maximum time
// - status: error bit 7, done bit 0
// - error on busy control access, short read
// - control access while busy stops operation
// - control: start, mode, direction, reserved bits
// - mode: block, key load, chained block
// - direction: encrypt, decrypt only in block mode
// - data area is key or block by mode
// - registers only through serial memory accesses
// - chained mode XORs input with previous result
// - key read gives last round key after encryption, cipher key after decryption
// - everything cleared in reset, locked in sleep; code only locks the link, a running operation still counts on and sets done
`timescale 1ns/1ns
`include "aesbe_params.svh"
module aesbe_engine
  import aesbe_pkg::*;
#(
  parameter int OP_CYCLES = `AESBE_OP_CYCLES
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // power state, same clock domain
  input wire logic sleep,
  // serial link pins
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n
);
  localparam int TW = $clog2(OP_CYCLES + 1);

  // ---------------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------------
  if (OP_CYCLES < `AESBE_CORE_LATENCY || OP_CYCLES > `AESBE_DONE_MAX_CYCLES) begin : g_bad
    $error("OP_CYCLES must cover the core latency and stay within the done limit");
  end

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic sclk_m, sclk_s, sclk_d, sel_n_m, sel_n_s, sel_n_d, mosi_m, mosi_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sel_n_m <= 1'b1;
      sel_n_s <= 1'b1;
      sel_n_d <= 1'b1;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sel_n_m <= sel_n;
      sel_n_s <= sel_n_m;
      sel_n_d <= sel_n_s;
      mosi_m <= mosi;
      mosi_s <= mosi_m;
    end
  end

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  aesbe_phase_t phase, next_phase;
  aesbe_eng_t eng, next_eng;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] rx_sr, next_rx_sr;
  logic [7:0] tx_sr, next_tx_sr, addr, next_addr;
  logic is_wr, next_is_wr;
  logic [4:0] rd_cnt, next_rd_cnt;
  aesbe_byte_t blk [16];
  aesbe_byte_t next_blk [16];
  aesbe_byte_t key [16];
  aesbe_byte_t next_key [16];
  logic [2:0] mode, next_mode;
  logic dir, next_dir, err, next_err, done, next_done;
  logic [127:0] prev_res, next_prev_res, last_key, next_last_key;
  logic [TW-1:0] timer, next_timer;
  logic core_start, next_core_start, core_dec, next_core_dec;
  logic [127:0] core_din, next_core_din;
  logic [127:0] blk_vec, key_vec, core_dout, core_kout;

  for (genvar g = 0; g < 16; g++) begin : g_vec
    assign blk_vec[127-8*g -: 8] = blk[g];
    assign key_vec[127-8*g -: 8] = key[g];
  end

  function automatic logic in_data(input logic [7:0] a);
    return a >= `AESBE_ADDR_DATA_FIRST && a <= `AESBE_ADDR_DATA_LAST;
  endfunction

  function automatic logic is_ctrl(input logic [7:0] a);
    return a == `AESBE_ADDR_CTRL || a == `AESBE_ADDR_CTRL_ALIAS;
  endfunction

  // byte shown to the host for an address of this block
  function automatic aesbe_byte_t rd_byte(input logic [7:0] a);
    aesbe_byte_t r;
    logic [3:0] i;
    r = 8'h00;
    i = 4'(a - `AESBE_ADDR_DATA_FIRST);
    if (a == `AESBE_ADDR_STATUS) begin
      r[`AESBE_STAT_ERR_BIT] = err;
      r[`AESBE_STAT_DONE_BIT] = done;
    end else if (is_ctrl(a)) begin
      r[`AESBE_CTRL_MODE_HI:`AESBE_CTRL_MODE_LO] = mode;
      r[`AESBE_CTRL_DIR_BIT] = dir;
    end else if (in_data(a)) begin
      r = (mode == `AESBE_MODE_KEY) ? last_key[127-8*i -: 8] : blk[i];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    aesbe_byte_t rx_byte, wr_byte;
    logic touch, start_req;
    logic [3:0] idx;
    rx_byte = {rx_sr, mosi_s};
    wr_byte = 8'h00;
    touch = 1'b0;
    start_req = 1'b0;
    idx = 4'(addr - `AESBE_ADDR_DATA_FIRST);
    next_phase = phase;
    next_eng = eng;
    next_bit_cnt = bit_cnt;
    next_rx_sr = rx_sr;
    next_tx_sr = tx_sr;
    next_addr = addr;
    next_is_wr = is_wr;
    next_rd_cnt = rd_cnt;
    next_blk = blk;
    next_key = key;
    next_mode = mode;
    next_dir = dir;
    next_err = err;
    next_done = done;
    next_prev_res = prev_res;
    next_last_key = last_key;
    next_timer = timer;
    next_core_start = 1'b0;
    next_core_dec = core_dec;
    next_core_din = core_din;

    // run time is fixed; core result stands long before the timer ends
    if (eng == ENG_RUN) begin
      next_timer = timer + TW'(1);
      if (timer == TW'(OP_CYCLES - 1)) begin
        next_eng = ENG_IDLE;
        next_done = 1'b1;
        next_prev_res = core_dout;
        next_last_key = core_kout;
        for (int i = 0; i < 16; i++) next_blk[i] = core_dout[127-8*i -: 8];
      end
    end

    // short read of the data block shows as error at frame end
    if (sel_n_s && !sel_n_d && phase == PH_DATA && !is_wr && rd_cnt != 5'h00
        && rd_cnt < `AESBE_DATA_BYTES) begin
      next_err = 1'b1;
    end

    if (sel_n_s || sleep) begin
      next_phase = PH_CMD;
      next_bit_cnt = 3'h0;
      next_tx_sr = 8'h00;
    end else if (sclk_s && !sclk_d) begin
      next_rx_sr = rx_byte[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      next_tx_sr = {tx_sr[6:0], 1'b0};
      if (bit_cnt == 3'h7) begin
        unique case (phase)
          PH_CMD: begin
            next_is_wr = (rx_byte[7:6] == `AESBE_CMD_WRITE);
            next_rd_cnt = 5'h00;
            next_phase = (rx_byte[7:6] == `AESBE_CMD_WRITE || rx_byte[7:6] == `AESBE_CMD_READ)
                         ? PH_ADDR : PH_IGNORE;
          end
          PH_ADDR: begin
            next_addr = rx_byte;
            next_phase = PH_DATA;
            if (!is_wr) begin
              next_tx_sr = rd_byte(rx_byte);
              touch = is_ctrl(rx_byte);
            end
          end
          PH_DATA: begin
            next_addr = addr + 8'h01;
            if (is_wr) begin
              // old content leaves one byte behind the new one
              next_tx_sr = rd_byte(addr);
              wr_byte = rx_byte;
              if (is_ctrl(addr)) begin
                touch = 1'b1;
                start_req = wr_byte[`AESBE_CTRL_START_BIT];
                next_mode = wr_byte[`AESBE_CTRL_MODE_HI:`AESBE_CTRL_MODE_LO];
                next_dir = wr_byte[`AESBE_CTRL_DIR_BIT];
              end else if (in_data(addr)) begin
                if (mode == `AESBE_MODE_KEY) next_key[idx] = wr_byte;
                else next_blk[idx] = wr_byte;
              end
            end else begin
              next_tx_sr = rd_byte(addr + 8'h01);
              touch = is_ctrl(addr + 8'h01);
              if (in_data(addr) && mode != `AESBE_MODE_KEY && rd_cnt != `AESBE_DATA_BYTES) begin
                next_rd_cnt = rd_cnt + 5'h01;
              end
            end
          end
          PH_IGNORE: begin
          end
        endcase
      end
    end

    if (touch) begin
      if (eng == ENG_RUN) begin
        next_eng = ENG_IDLE;
        next_err = 1'b1;
      end else if (start_req) begin
        if (next_mode == `AESBE_MODE_ECB
            || (next_mode == `AESBE_MODE_CBC && !next_dir)) begin
          next_eng = ENG_RUN;
          next_timer = '0;
          next_done = 1'b0;
          next_err = 1'b0;
          next_core_start = 1'b1;
          next_core_dec = next_dir;
          next_core_din = (next_mode == `AESBE_MODE_CBC) ? blk_vec ^ prev_res : blk_vec;
        end else begin
          next_err = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= PH_CMD;
      eng <= ENG_IDLE;
      bit_cnt <= 3'h0;
      rx_sr <= 7'h00;
      tx_sr <= 8'h00;
      addr <= 8'h00;
      is_wr <= 1'b0;
      rd_cnt <= 5'h00;
      for (int i = 0; i < 16; i++) begin
        blk[i] <= 8'h00;
        key[i] <= 8'h00;
      end
      mode <= `AESBE_MODE_ECB;
      dir <= 1'b0;
      err <= 1'b0;
      done <= 1'b0;
      prev_res <= '0;
      last_key <= '0;
      timer <= '0;
      core_start <= 1'b0;
      core_dec <= 1'b0;
      core_din <= '0;
    end else begin
      phase <= next_phase;
      eng <= next_eng;
      bit_cnt <= next_bit_cnt;
      rx_sr <= next_rx_sr;
      tx_sr <= next_tx_sr;
      addr <= next_addr;
      is_wr <= next_is_wr;
      rd_cnt <= next_rd_cnt;
      blk <= next_blk;
      key <= next_key;
      mode <= next_mode;
      dir <= next_dir;
      err <= next_err;
      done <= next_done;
      prev_res <= next_prev_res;
      last_key <= next_last_key;
      timer <= next_timer;
      core_start <= next_core_start;
      core_dec <= next_core_dec;
      core_din <= next_core_din;
    end
  end

  // ---------------------------------------------------------------------
  // cipher core and pins
  // ---------------------------------------------------------------------
  aesbe_core u_core (
    .clk(clk),
    .rst(rst),
    .start(core_start),
    .decrypt(core_dec),
    .key_in(key_vec),
    .data_in(core_din),
    .data_out(core_dout),
    .key_out(core_kout)
  );

  assign miso = tx_sr[7];
  assign miso_oe_n = sel_n_s | sleep;
endmodule

/* test/aesbe_engine_assertions.sv */
// pin-level checks of the serial block cipher engine
`timescale 1ns/1ns
module aesbe_engine_checker
  import aesbe_pkg::*;
#(
  parameter int OP_CYCLES = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // power state
  input wire logic sleep,
  // serial link
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic sclk_q, next_sclk_q, rise;
  logic [7:0] since_rise, next_since_rise, rises, next_rises;
  logic [1:0] cmd, next_cmd;
  assign rise = sclk && !sclk_q;
  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  always_comb begin
    next_sclk_q = sclk;
    next_since_rise = rise ? 8'h00 : since_rise + {7'h00, since_rise != 8'hFF};
    next_rises = sel_n ? 8'h00 : rises + {7'h00, rise};
    next_cmd = (rise && rises < 8'h02) ? {cmd[0], mosi} : cmd;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      since_rise <= 8'hFF;
      rises <= 8'h00;
      cmd <= 2'h0;
    end else begin
      sclk_q <= next_sclk_q;
      since_rise <= next_since_rise;
      rises <= next_rises;
      cmd <= next_cmd;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_release_idle;
    $fell(rst) |-> miso_oe_n && !miso;
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("link driven after reset");
  property p_sleep_quiet;
    sleep |-> miso_oe_n;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("miso driven in sleep");
  property p_deselect_quiet;
    sel_n [*4] |-> miso_oe_n;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("miso driven idle");
  property p_select_drive;
    (!sel_n && !sleep) [*4] |-> !miso_oe_n;
  endproperty
  a_select_drive: assert property (p_select_drive) else $error("miso not driven");
  property p_end_release;
    $rose(sel_n) |-> ##[1:4] miso_oe_n;
  endproperty
  a_end_release: assert property (p_end_release) else $error("miso held after frame");
  property p_oe_follows;
    $fell(sel_n) && !sleep ##1 !sel_n [*3] |-> !miso_oe_n;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("miso enable late");
  property p_miso_paced;
    (!miso_oe_n [*3] ##0 !$stable(miso)) |-> since_rise <= 8'h06;
  endproperty
  a_miso_paced: assert property (p_miso_paced) else $error("miso moved off pace");
  property p_first_byte_zero;
    (rise && !sel_n && cmd == 2'h1 && rises >= 8'h10 && rises <= 8'h17) |-> !miso;
  endproperty
  a_first_byte_zero: assert property (p_first_byte_zero) else $error("first write byte");
  c_write_frame: cover property (rises == 8'h98 && cmd == 2'h1);
  c_read_frame: cover property (rises == 8'h18 && cmd == 2'h0);
  c_sleep: cover property ($rose(sleep));
endmodule

bind aesbe_engine aesbe_engine_checker #(.OP_CYCLES(OP_CYCLES)) u_checker (.clk(clk),
  .rst(rst), .sleep(sleep), .sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso),
  .miso_oe_n(miso_oe_n));

/* test/aesbe_host_model.sv */
// host side of the serial link: sends frames and gathers miso bytes
`timescale 1ns/1ns
module aesbe_host_model (
  // serial link
  output logic sclk,
  output logic sel_n,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] tx [0:19];
  logic [7:0] rx [0:19];
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b1;
  end
  // link clock stands still outside frames
  task automatic frame(input int n);
    // offset and closing gap keep link edges off the system clock edges
    #2;
    sel_n = 1'b0;
    #62;
    for (int k = 0; k < n; k++) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = tx[k][b];
        #63;
        rx[k][b] = miso;
        sclk = 1'b1;
        #62;
        sclk = 1'b0;
      end
    end
    #63;
    sel_n = 1'b1;
    mosi = ~mosi;
    #253;
  endtask
endmodule

/* test/aes_block_engine_sram_port_test.sv */
// self-checking bench of the serial block cipher engine
`timescale 1ns/1ns
module aes_block_engine_sram_port_test;
  import aesbe_pkg::*;
  localparam int OP = 300;
  typedef struct packed {logic [7:0] wa, wd, ra, ex;} aesbe_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sleep = 1'b0;
  logic sclk, sel_n, mosi, miso, miso_oe_n, miso_line;
  logic [7:0] v;
  logic [127:0] got, lrk;
  logic [127:0] ct0 = 128'h66E94BD4EF8A2C3B884CFA59CA342B2E;
  int err_count = 0;
  int n_compared = 0;
  aesbe_row_t rows [0:11] = '{
    '{8'h83, 8'h28, 8'h83, 8'h28},
    '{8'h83, 8'h7F, 8'h83, 8'h78},
    '{8'h94, 8'h10, 8'h83, 8'h10},
    '{8'h83, 8'h18, 8'h94, 8'h18},
    '{8'h82, 8'hFF, 8'h82, 8'h00},
    '{8'h95, 8'h55, 8'h95, 8'h00},
    '{8'h83, 8'hF0, 8'h82, 8'h80},
    '{8'h83, 8'h80, 8'h82, 8'h01},
    '{8'h83, 8'h90, 8'h82, 8'h81},
    '{8'h94, 8'hA8, 8'h82, 8'h81},
    '{8'h94, 8'hA0, 8'h82, 8'h01},
    '{8'h83, 8'h88, 8'h82, 8'h01}
  };
  always #5 clk = ~clk;
  // released miso line floats: show a moving pattern
  assign miso_line = miso_oe_n ? ~sclk : miso;
  aesbe_engine #(.OP_CYCLES(OP)) DUT (.clk(clk), .rst(rst), .sleep(sleep), .sclk(sclk),
    .sel_n(sel_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));
  aesbe_host_model host (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso_line));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check128(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [127:0] get_block(input int at);
    logic [127:0] r;
    for (int i = 0; i < 16; i++)
      r[127 - 8 * i -: 8] = host.rx[at + i];
    return r;
  endfunction
  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input int n);
    host.tx[0] = c;
    host.tx[1] = a;
    host.frame(n + 2);
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    host.tx[2] = d;
    xfer(8'h40, a, 1);
  endtask
  task automatic rd1(input logic [7:0] a, output logic [7:0] d);
    xfer(8'h00, a, 1);
    d = host.rx[2];
  endtask
  // control, sixteen block bytes and the alias in one fast access
  task automatic blk(input logic [7:0] c, input logic [127:0] d, input logic [7:0] last);
    host.tx[2] = c;
    for (int i = 0; i < 16; i++)
      host.tx[3 + i] = d[127 - 8 * i -: 8];
    host.tx[19] = last;
    xfer(8'h40, 8'h83, 18);
  endtask
  task automatic run_wait;
    repeat (OP + 60) @(posedge clk);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr1(rows[i].wa, rows[i].wd);
      run_wait();
      rd1(rows[i].ra, v);
      check8(v, rows[i].ex);
    end
    @(posedge clk);
    sleep <= 1'b1;
    wr1(8'h83, 8'h00);
    @(posedge clk);
    sleep <= 1'b0;
    rd1(8'h83, v);
    check8(v, 8'h08);
    wr1(8'h83, 8'h80);
    rd1(8'h83, v);
    rd1(8'h82, v);
    check8(v, 8'h80);
    do_reset();
    rd1(8'h82, v);
    check8(v, 8'h00);
    host.tx[2] = 8'h20;
    xfer(8'hC0, 8'h83, 1);
    rd1(8'h83, v);
    check8(v, 8'h00);
    blk(8'h00, 128'h0, 8'h80);
    check128(get_block(4), 128'h0);
    run_wait();
    blk(8'h20, ct0, 8'hA0);
    check128(get_block(4), ct0);
    check8(host.rx[3], 8'h00);
    run_wait();
    blk(8'h00, 128'h0, 8'h00);
    check128(get_block(4), ct0);
    xfer(8'h00, 8'h84, 4);
    got = get_block(2);
    check128(got & {32'hFFFFFFFF, 96'h0}, 128'h0);
    rd1(8'h82, v);
    check8(v, 8'h81);
    wr1(8'h83, 8'h10);
    xfer(8'h00, 8'h84, 16);
    lrk = get_block(2);
    blk(8'h10, lrk, 8'h08);
    blk(8'h08, ct0, 8'h88);
    run_wait();
    blk(8'h00, 128'h0, 8'h00);
    check128(get_block(4), 128'h0);
    rd1(8'h82, v);
    check8(v, 8'h01);
    finish_test();
  end
  initial begin
    #600000;
    err_count++;
    finish_test();
  end
endmodule
